// ### rtl/vsts_pkg.sv
package vsts_pkg;

  // Build defaults for the trace hub and its monitors.
  localparam int NMON_DEF = 2;
  localparam int CAP_W = 32;
  localparam int FIFO_DEPTH_DEF = 16384;
  localparam int BPS_DEF = 8;
  localparam int PAR_DEF = 3;
  localparam int SEQ_DEF = 1;

  // Event message layout: kind, monitor index, payload.
  localparam int KIND_W = 2;
  localparam int ID_W = 2;
  localparam int PAY_W = 28;
  localparam logic [1:0] KIND_STAT = 2'h1;
  localparam logic [1:0] KIND_PIX = 2'h2;

  // Packet type carried in the low bits of the first beat of a packet.
  localparam int PKT_TYPE_W = 4;
  localparam logic [3:0] PKT_VIDEO = 4'h0;

  // Register map, byte addresses on the bus.
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_HUB_CTRL = 8'h00;
  localparam logic [7:0] REG_HUB_LEVEL = 8'h04;
  localparam logic [7:0] REG_HUB_DROPS = 8'h08;
  localparam logic [7:0] MON_BASE = 8'h10;
  localparam int MON_STRIDE_SH = 4;
  localparam logic [3:0] MON_CTRL = 4'h0;
  localparam logic [3:0] MON_RATE = 4'h4;
  localparam logic [3:0] MON_XFER = 4'h8;
  localparam logic [3:0] MON_WAIT = 4'hC;

  // Control bit positions.
  localparam int CTRL_RUN_BIT = 0;
  localparam int MON_EN_BIT = 0;
  localparam int MON_PIX_BIT = 1;
  localparam int MON_CLR_BIT = 2;

  // Reset values.
  localparam logic RUN_RST = 1'b0;
  localparam logic [15:0] RATE_RST = 16'h0000;

  // Output buffer toward the host link.
  localparam int OBUF_DEPTH = 2;

endpackage

// ### rtl/vsts_trace.sv
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
module vsts_trace #(
  parameter int NMON = vsts_pkg::NMON_DEF,
  parameter int DEPTH = vsts_pkg::FIFO_DEPTH_DEF,
  parameter int BPS = vsts_pkg::BPS_DEF,
  parameter int PAR = vsts_pkg::PAR_DEF,
  parameter int SEQ = vsts_pkg::SEQ_DEF,
  parameter bit CAPTURE_PIXELS = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [vsts_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NMON-1:0] src_valid_i,
  input wire logic [NMON-1:0][BPS*PAR-1:0] src_data_i,
  input wire logic [NMON-1:0] src_sop_i,
  input wire logic [NMON-1:0] src_eop_i,
  output logic [NMON-1:0] src_ready_o,
  output logic [NMON-1:0] snk_valid_o,
  output logic [NMON-1:0][BPS*PAR-1:0] snk_data_o,
  output logic [NMON-1:0] snk_sop_o,
  output logic [NMON-1:0] snk_eop_o,
  input wire logic [NMON-1:0] snk_ready_i,
  output logic [vsts_pkg::CAP_W-1:0] host_data_o,
  output logic host_valid_o,
  input wire logic host_ready_i
);

  localparam int DW = BPS * PAR;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = vsts_pkg::CAP_W;
  localparam int ADR_W_T = vsts_pkg::ADR_W;
  localparam int PW = vsts_pkg::PAY_W;
  localparam int IW = vsts_pkg::ID_W;
  localparam int SEQ_KEPT = SEQ;

  typedef struct packed {
    logic run;
    logic [31:0] drops;
    logic [NMON-1:0] en;
    logic [NMON-1:0] pix;
    logic [NMON-1:0][15:0] rate;
    logic [NMON-1:0][15:0] gap;
    logic [NMON-1:0][31:0] xfer;
    logic [NMON-1:0][15:0] swait;
    logic [NMON-1:0][15:0] kwait;
    logic [NMON-1:0] in_vid;
    logic [NMON-1:0] stg_v;
    logic [NMON-1:0][CW-1:0] stg_d;
    logic [IW-1:0] rr;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic rd_pend;
    logic [1:0] bcnt;
    logic [CW-1:0] b0;
    logic [CW-1:0] b1;
    logic ack;
    logic [31:0] rdat;
  } vsts_state_s;

  vsts_state_s st_r;
  vsts_state_s st_nxt;
  logic [CW-1:0] mem [DEPTH];
  logic [CW-1:0] mem_q;
  logic fifo_we;
  logic [CW-1:0] fifo_wd;
  logic rd_go;

  // Merge new bits into a stored word under the bus byte lanes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  // series link
  // The stream wires pass straight through, so the monitor adds no latency and no stall.
  genvar g;
  generate
    for (g = 0; g < NMON; g++)
    begin : g_tap
      assign snk_valid_o[g] = src_valid_i[g];
      assign snk_data_o[g] = src_data_i[g];
      assign snk_sop_o[g] = src_sop_i[g];
      assign snk_eop_o[g] = src_eop_i[g];
      assign src_ready_o[g] = snk_ready_i[g];
    end
  endgenerate

  // Host side and bus outputs come straight from the buffer and bus slave registers.
  assign host_valid_o = (st_r.bcnt != 2'h0);
  assign host_data_o = st_r.b0;
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;

  // Next state of the monitors, the hub, the buffer and the bus slave.
  always_comb
  begin
    logic beat;
    logic emit;
    logic [CW-1:0] msg;
    logic [AW:0] level;
    logic wr_hit;
    logic [31:0] wv;
    logic [ADR_W_T-1:0] moff;
    int mi;
    int pick;
    int idx;
    logic pop;
    logic [2:0] room;
    beat = 1'b0;
    emit = 1'b0;
    msg = '0;
    level = st_r.wp - st_r.rp;
    wr_hit = wb_cyc_i & wb_stb_i & ~st_r.ack;
    wv = '0;
    moff = wb_adr_i - vsts_pkg::MON_BASE;
    mi = int'(moff >> vsts_pkg::MON_STRIDE_SH);
    pick = -1;
    idx = 0;
    pop = 1'b0;
    room = '0;
    st_nxt = st_r;
    fifo_we = 1'b0;
    fifo_wd = '0;
    rd_go = 1'b0;

    // merge feeds
    // Round robin pick among the staged events; one enters the FIFO per cycle.
    for (int i = 0; i < NMON; i++)
    begin
      idx = (int'(st_r.rr) + i) % NMON;
      if (pick < 0 && st_r.stg_v[idx])
        pick = idx;
    end
    if (pick >= 0 && st_r.run && level != (AW+1)'(DEPTH))
    begin
      fifo_we = 1'b1;
      fifo_wd = st_r.stg_d[pick];
      st_nxt.wp = st_r.wp + 1'b1;
      st_nxt.stg_v[pick] = 1'b0;
      st_nxt.rr = IW'((pick + 1) % NMON);
    end
    else if (pick >= 0 && !st_r.run)
    begin
      // A stopped hub flushes the stages rather than holding old events.
      for (int i = 0; i < NMON; i++)
        st_nxt.stg_v[i] = 1'b0;
    end

    // Per monitor capture, statistics and rate limiting.
    for (int m = 0; m < NMON; m++)
    begin
      beat = src_valid_i[m] & snk_ready_i[m];
      emit = 1'b0;
      msg = '0;
      if (st_r.gap[m] != 16'h0000)
        st_nxt.gap[m] = st_r.gap[m] - 16'h0001;
      if (st_r.en[m])
      begin
        if (beat)
          st_nxt.xfer[m] = st_r.xfer[m] + 32'h0000_0001;
        if (!src_valid_i[m] && snk_ready_i[m])
          st_nxt.swait[m] = st_r.swait[m] + 16'h0001;
        if (src_valid_i[m] && !snk_ready_i[m])
          st_nxt.kwait[m] = st_r.kwait[m] + 16'h0001;
      end
      if (beat && src_sop_i[m])
        st_nxt.in_vid[m] = ~src_eop_i[m] &&
          (src_data_i[m][vsts_pkg::PKT_TYPE_W-1:0] == vsts_pkg::PKT_VIDEO);
      else if (beat && src_eop_i[m])
        st_nxt.in_vid[m] = 1'b0;
      if (beat && st_r.pix[m] && CAPTURE_PIXELS && st_r.in_vid[m] && !src_sop_i[m])
      begin
        emit = 1'b1;
        msg = {vsts_pkg::KIND_PIX, IW'(m), PW'(src_data_i[m])};
      end
      else if (beat && !st_r.pix[m] && src_eop_i[m])
      begin
        emit = 1'b1;
        msg = {vsts_pkg::KIND_STAT, IW'(m), st_r.xfer[m][PW-1:0]};
      end
      if (emit && st_r.en[m] && st_r.gap[m] == 16'h0000)
      begin
        st_nxt.gap[m] = st_r.rate[m];
        if (!st_nxt.stg_v[m])
        begin
          st_nxt.stg_v[m] = 1'b1;
          st_nxt.stg_d[m] = msg;
        end
        else
          st_nxt.drops = st_r.drops + 32'h0000_0001;
      end
    end

    // drain to host
    // Two entry buffer: a stalled host keeps both words, and reads stop until room returns.
    pop = host_valid_o & host_ready_i;
    if (pop)
    begin
      st_nxt.b0 = st_r.b1;
      st_nxt.bcnt = st_r.bcnt - 2'h1;
    end
    if (st_r.rd_pend)
    begin
      if (st_nxt.bcnt == 2'h0)
        st_nxt.b0 = mem_q;
      else
        st_nxt.b1 = mem_q;
      st_nxt.bcnt = st_nxt.bcnt + 2'h1;
    end
    room = {1'b0, st_r.bcnt} + {2'h0, st_r.rd_pend};
    rd_go = (st_r.wp != st_r.rp) && (room < 3'(vsts_pkg::OBUF_DEPTH));
    st_nxt.rd_pend = rd_go;
    if (rd_go)
      st_nxt.rp = st_r.rp + 1'b1;

    // setup registers
    // Single cycle slave: ack one cycle after the strobe, dropped the next cycle.
    st_nxt.ack = wr_hit;
    if (wr_hit)
    begin
      wv = '0;
      if (wb_adr_i == vsts_pkg::REG_HUB_CTRL)
      begin
        wv[vsts_pkg::CTRL_RUN_BIT] = st_r.run;
        if (wb_we_i && wb_sel_i[0])
          st_nxt.run = wb_dat_i[vsts_pkg::CTRL_RUN_BIT];
      end
      else if (wb_adr_i == vsts_pkg::REG_HUB_LEVEL)
        wv = 32'(level);
      else if (wb_adr_i == vsts_pkg::REG_HUB_DROPS)
      begin
        wv = st_r.drops;
        if (wb_we_i)
          st_nxt.drops = 32'h0000_0000;
      end
      else if (wb_adr_i >= vsts_pkg::MON_BASE && mi < NMON)
      begin
        case (moff[3:0])
          vsts_pkg::MON_CTRL:
          begin
            wv[vsts_pkg::MON_EN_BIT] = st_r.en[mi];
            wv[vsts_pkg::MON_PIX_BIT] = st_r.pix[mi];
            if (wb_we_i && wb_sel_i[0])
            begin
              st_nxt.en[mi] = wb_dat_i[vsts_pkg::MON_EN_BIT];
              st_nxt.pix[mi] = wb_dat_i[vsts_pkg::MON_PIX_BIT];
              if (wb_dat_i[vsts_pkg::MON_CLR_BIT])
              begin
                st_nxt.xfer[mi] = 32'h0000_0000;
                st_nxt.swait[mi] = 16'h0000;
                st_nxt.kwait[mi] = 16'h0000;
              end
            end
          end
          vsts_pkg::MON_RATE:
          begin
            wv = {16'h0000, st_r.rate[mi]};
            if (wb_we_i)
              st_nxt.rate[mi] = 16'(lane_merge(wv, wb_dat_i, wb_sel_i));
          end
          vsts_pkg::MON_XFER:
            wv = st_r.xfer[mi];
          vsts_pkg::MON_WAIT:
            wv = {st_r.kwait[mi], st_r.swait[mi]};
          default:
            wv = '0;
        endcase
      end
      st_nxt.rdat = wb_we_i ? 32'h0000_0000 : wv;
    end
  end

  // shared reset
  // All control state registers here; reset clears every flag and counter.
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      st_r <= '0;
      st_r.run <= vsts_pkg::RUN_RST;
      for (int m = 0; m < NMON; m++)
        st_r.rate[m] <= vsts_pkg::RATE_RST;
    end
    else
      st_r <= st_nxt;
  end

  // The FIFO body stays outside the state record so it maps to block memory.
  always_ff @(posedge ref_clk_i)
  begin
    if (fifo_we)
      mem[st_r.wp[AW-1:0]] <= fifo_wd;
    if (rd_go)
      mem_q <= mem[st_r.rp[AW-1:0]];
  end

  // format match
  // Format parameters only size the data path; SEQ is kept for matching with neighbours.
  logic unused_seq;
  assign unused_seq = (SEQ_KEPT == 0);

endmodule

// ### testbench/vsts_trace_chk.sv
`timescale 1ns/100ps
// Watches the bus, the tapped links and the host side of the trace block.
module vsts_trace_chk #(
  parameter int NMON = 2,
  parameter int BPS = 8,
  parameter int PAR = 3
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NMON-1:0] src_valid_i,
  input wire logic [NMON-1:0][BPS*PAR-1:0] src_data_i,
  input wire logic [NMON-1:0] src_ready_o,
  input wire logic [NMON-1:0] snk_valid_o,
  input wire logic [NMON-1:0][BPS*PAR-1:0] snk_data_o,
  input wire logic [NMON-1:0] snk_ready_i,
  input wire logic [31:0] host_data_o,
  input wire logic host_valid_o,
  input wire logic host_ready_i
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  ready_pass_a: assert property (src_ready_o == snk_ready_i)
    else $error("monitor altered ready");
  stream_pass_a: assert property (snk_valid_o == src_valid_i && snk_data_o == src_data_i)
    else $error("stream altered");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("late bus answer");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i &&
    (wb_adr_i >= 8'h30 || wb_adr_i == 8'h0C) |-> wb_dat_o == 32'h0) else $error("unmapped data");
  write_zero_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("write data nonzero");
  host_hold_a: assert property (host_valid_o && !host_ready_i |=>
    host_valid_o && $stable(host_data_o)) else $error("host word lost");
  reset_idle_a: assert property (disable iff (1'b0) srst_i |=> !host_valid_o && !wb_ack_o)
    else $error("active in reset");
endmodule

bind vsts_trace vsts_trace_chk #(.NMON(NMON), .BPS(BPS), .PAR(PAR)) u_vsts_trace_chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .src_valid_i(src_valid_i), .src_data_i(src_data_i), .src_ready_o(src_ready_o),
  .snk_valid_o(snk_valid_o), .snk_data_o(snk_data_o), .snk_ready_i(snk_ready_i),
  .host_data_o(host_data_o), .host_valid_o(host_valid_o), .host_ready_i(host_ready_i));

// ### testbench/vsts_host_model.sv
`timescale 1ns/100ps
// Host end of the trace link; a slow host takes words on a pseudo-random pattern.
module vsts_host_model (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic stall_i,
  input wire logic host_valid_i,
  input wire logic [31:0] host_data_i,
  output logic host_ready_o,
  output logic got_o,
  output logic [31:0] word_o
);
  logic [7:0] lfsr_r;

  always_ff @(posedge ref_clk_i)
  begin
    lfsr_r <= srst_i ? 8'hA5 : {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5]};
    host_ready_o <= !srst_i && !stall_i && (!slow_i || lfsr_r[0]);
    got_o <= host_valid_i && host_ready_o;
    word_o <= host_data_i;
  end
endmodule

// ### testbench/vsts_trace_tb.sv
`timescale 1ns/100ps
module vsts_trace_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, hv, hr, got;
  logic slow = 1'b0, stall = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, wb_q, hd, word;
  logic [1:0] sv = 2'h0, sop = 2'h0, eop = 2'h0, rdy = 2'h3, srdy, kv, ks, ke;
  logic [1:0][23:0] sd = 48'h0, kd;
  logic [7:0] zadr[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h30};
  logic [31:0] expq[$];
  int seed = 32'hF187;
  int bad_count = 0, compares = 0, i, n;

  vsts_trace #(.DEPTH(16)) u_vsts_trace (.ref_clk_i(clk), .srst_i(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .src_valid_i(sv), .src_data_i(sd), .src_sop_i(sop),
    .src_eop_i(eop), .src_ready_o(srdy), .snk_valid_o(kv), .snk_data_o(kd), .snk_sop_o(ks),
    .snk_eop_o(ke), .snk_ready_i(rdy), .host_data_o(hd), .host_valid_o(hv), .host_ready_i(hr));
  vsts_host_model u_vsts_host_model (.ref_clk_i(clk), .srst_i(srst), .slow_i(slow),
    .stall_i(stall), .host_valid_i(hv), .host_data_i(hd), .host_ready_o(hr), .got_o(got),
    .word_o(word));

  // Free-running 200 MHz clock.
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Classic single cycle; the request stands until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    wb_q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50)
    begin
      bad_count++;
      $display("FAIL %0t bus hang", $time);
      stop_test();
    end
  endtask

  function automatic logic [7:0] madr(input int m, input logic [3:0] off);
    return vsts_pkg::MON_BASE + 8'(m << vsts_pkg::MON_STRIDE_SH) + {4'h0, off};
  endfunction

  function automatic logic [31:0] stat_w(input int id, input int c);
    return {vsts_pkg::KIND_STAT, 2'(id), 28'(c)};
  endfunction

  function automatic logic [31:0] pix_w(input int id, input logic [23:0] d);
    return {vsts_pkg::KIND_PIX, 2'(id), 28'(d)};
  endfunction

  // Sends one packet; its first beat carries the type, and video packets expect pixel words.
  task automatic pkt(input int m, input logic [3:0] typ, input int cnt);
    logic [23:0] d;
    int b;
    for (b = 0; b < cnt; b++)
    begin
      d = 24'($random(seed));
      if (b == 0)
        d[3:0] = typ;
      else if (typ == vsts_pkg::PKT_VIDEO)
        expq.push_back(pix_w(m, d));
      @(posedge clk);
      sv[m] <= 1'b1;
      sop[m] <= b == 0;
      eop[m] <= b == cnt - 1;
      sd[m] <= d;
    end
    @(posedge clk);
    sv[m] <= 1'b0;
    sop[m] <= 1'b0;
    eop[m] <= 1'b0;
  endtask

  // Sends cnt accepted beats; the last one, or every one, closes a packet.
  task automatic send(input int m, input int cnt, input bit all);
    int b;
    for (b = 0; b < cnt; b++)
    begin
      @(posedge clk);
      sv[m] <= 1'b1;
      eop[m] <= all || b == cnt - 1;
      sd[m] <= 24'($random(seed));
    end
    @(posedge clk);
    sv[m] <= 1'b0;
    eop[m] <= 1'b0;
  endtask

  // Waits, with a limit, until every expected word has reached the host.
  task automatic drain(input int lim);
    int k;
    k = 0;
    while (expq.size() > 0 && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    if (expq.size() > 0)
    begin
      bad_count++;
      $display("FAIL %0t host words missing", $time);
      stop_test();
    end
  endtask

  // Every word taken by the host must be the next one expected, in order.
  always @(posedge clk)
    if (got === 1'b1)
    begin
      if (expq.size() == 0)
        chk(64'h0, 64'h1);
      else
        chk(word, expq.pop_front());
    end

  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      sv <= 2'($random(seed));
      sop <= 2'($random(seed));
      eop <= 2'($random(seed));
      rdy <= 2'($random(seed));
      sd <= 48'({$random(seed), $random(seed)});
      #1;
      chk(kd, sd);
      chk({kv, ks, ke, srdy}, {sv, sop, eop, rdy});
    end
    @(posedge clk);
    sv <= 2'h0;
    sop <= 2'h0;
    eop <= 2'h0;
    rdy <= 2'h3;
    $display("test passthrough done");
    wb(1'b1, 8'h30, 32'hFFFFFFFF);
    foreach (zadr[j])
    begin
      wb(1'b0, zadr[j], 32'h0);
      chk(wb_q, 32'h0);
    end
    $display("test reset map done");
    wb(1'b1, vsts_pkg::REG_HUB_CTRL, 32'h1);
    send(0, 3, 1'b0);
    send(1, 2, 1'b0);
    repeat (20) @(posedge clk);
    $display("test disabled monitors done");
    for (n = 0; n < 2; n++)
    begin
      wb(1'b1, madr(n, vsts_pkg::MON_CTRL), 32'h5);
      expq.push_back(stat_w(n, 4));
      send(n, 5, 1'b0);
      drain(40);
      wb(1'b0, madr(n, vsts_pkg::MON_XFER), 32'h0);
      chk(wb_q, 32'h5);
    end
    @(posedge clk);
    rdy[0] <= 1'b0;
    sv[0] <= 1'b1;
    repeat (3) @(posedge clk);
    sv[0] <= 1'b0;
    rdy[0] <= 1'b1;
    wb(1'b0, madr(0, vsts_pkg::MON_WAIT), 32'h0);
    chk(wb_q[31:16], 16'h3);
    $display("test statistics done");
    wb(1'b1, madr(1, vsts_pkg::MON_RATE), 32'h4);
    wb(1'b0, madr(1, vsts_pkg::MON_RATE), 32'h0);
    chk(wb_q, 32'h4);
    wb(1'b1, madr(1, vsts_pkg::MON_CTRL), 32'h5);
    expq.push_back(stat_w(1, 0));
    expq.push_back(stat_w(1, 3));
    send(1, 3, 1'b1);
    repeat (10) @(posedge clk);
    send(1, 1, 1'b0);
    drain(60);
    $display("test rate cap done");
    stall <= 1'b1;
    wb(1'b1, madr(0, vsts_pkg::MON_CTRL), 32'h5);
    for (i = 0; i < 24; i++)
      expq.push_back(stat_w(0, i));
    send(0, 24, 1'b1);
    repeat (8) @(posedge clk);
    wb(1'b0, vsts_pkg::REG_HUB_LEVEL, 32'h0);
    chk(wb_q, 32'h10);
    wb(1'b0, vsts_pkg::REG_HUB_DROPS, 32'h0);
    n = wb_q;
    // The FIFO, the two host buffer words and the one input stage take the rest.
    chk(wb_q, 32'(24 - 16 - vsts_pkg::OBUF_DEPTH - 1));
    repeat (n) void'(expq.pop_back());
    slow <= 1'b1;
    stall <= 1'b0;
    drain(400);
    $display("test full buffer done");
    wb(1'b1, madr(0, vsts_pkg::MON_CTRL), 32'h3);
    pkt(0, vsts_pkg::PKT_VIDEO, 3);
    pkt(0, 4'h1, 3);
    drain(100);
    $display("test pixel capture done");
    // A reset in mid run must bring the hub control, monitor 1 rate and monitor 0 control registers back to their reset values.
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wb(1'b0, vsts_pkg::REG_HUB_CTRL, 32'h0);
    chk(wb_q, 32'(vsts_pkg::RUN_RST));
    wb(1'b0, madr(1, vsts_pkg::MON_RATE), 32'h0);
    chk(wb_q, 32'(vsts_pkg::RATE_RST));
    wb(1'b0, madr(0, vsts_pkg::MON_CTRL), 32'h0);
    chk(wb_q, 32'h0);
    $display("test mid reset done");
    stop_test();
  end
endmodule
